// ### verilog/llpm_top.v
// Purpose: Light-load phase manager of a multiphase core regulator
// Assumes: Serial VID receiver delivers decoded data bytes
// Notes:   Analog sensing outside; samples arrive digitised
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "llpm_map.vh"

module llpm_top (
    input  wire        clk_i,                   // Core clock, 20 MHz
    input  wire        rst_i,                   // Synchronous reset
    // Wishbone slave
    input  wire        wb_cyc_i,                // Cycle
    input  wire        wb_stb_i,                // Strobe
    input  wire        wb_we_i,                 // Write enable
    input  wire [3:0]  wb_adr_i,                // Byte address
    input  wire [3:0]  wb_sel_i,                // Byte lanes
    input  wire [31:0] wb_dat_i,                // Write data
    output reg  [31:0] wb_dat_o,                // Read data
    output reg         wb_ack_o,                // Acknowledge
    // Serial VID link, decoded
    input  wire        vid_cmd_i,               // Voltage-set command pulse
    input  wire        vid_core_i,              // Command addresses core
    input  wire        vid_nb_i,                // Command addresses northbridge
    input  wire [7:0]  vid_data_i,              // Data byte
    input  wire        serial_vid_clock_i,      // Clock line level
    input  wire        serial_vid_data_i,       // Data line level
    input  wire        cpu_power_ok_i,          // CPU power ok
    input  wire        overvoltage_fixmode_pin_n_i, // Low enters fixed mode
    input  wire        vid_transition_i,        // On-the-fly move in progress
    input  wire        drv_hiz_pwm_i,           // Drivers tri-state via PWM
    // Power-save pin
    input  wire [1:0]  strat_sense_i,           // Divider sense on pin
    input  wire        power_save_pin_i,        // Pin level (unused by logic)
    output wire        power_save_pin_o,        // Pin drive value (low)
    output wire        power_save_pin_oe_o,     // Pin pulled low
    // Phases
    input  wire [3:0]  pwm_strap_gnd_i,         // PWM pin strapped to ground
    input  wire [31:0] phase_current_info_i,    // Four current samples
    output reg  [3:0]  phase_pwm_out_o,         // PWM levels
    output reg  [3:0]  phase_pwm_oe_o,          // PWM driven (low = HiZ)
    output reg         driver_enable_out_o,     // Core driver enable
    output reg         nb_pwm_oe_o,             // Northbridge PWM driven
    output reg         nb_driver_enable_o,      // Northbridge driver enable
    output reg         power_good_out_o,        // Power good
    output reg         fixed_mode_o,            // Fixed-voltage mode
    output reg         serial_mode_o,           // Serial VID mode
    output reg  [1:0]  fixed_code_o,            // Static code in fixed mode
    output reg  [6:0]  core_vid_o,              // Core VID code
    output reg  [6:0]  nb_vid_o,                // Northbridge VID code
    output reg  [7:0]  average_phase_current_o, // Average reference
    output reg  [35:0] share_trim_o             // Per-phase duty trims
);

    // One-hot sequencer states
    localparam [2:0] ST_OFF  = 3'b001;          // Drivers off
    localparam [2:0] ST_SOFT = 3'b010;          // Soft-start
    localparam [2:0] ST_RUN  = 3'b100;          // Regulating

    localparam integer PER_MAX = `LLPM_CLK_KHZ / `LLPM_OSC_KHZ; // Clocks per period

    reg  [2:0]  state;          // Sequencer
    reg  [2:0]  next_state;     // Next sequencer
    reg  [31:0] ctrl;           // Control register
    reg  [7:0]  pwm_per;        // PWM period, clocks
    reg  [7:0]  pwm_cnt;        // Period counter
    reg         flag_n;         // Received flag, active low
    reg  [1:0]  strategy;       // Latched strategy
    reg  [2:0]  cfg_phases;     // Strapped count
    reg  [2:0]  act_n;          // Working count in force
    reg  [7:0]  duty;           // Shared duty, clocks
    wire [2:0]  sel_n;          // Proposed working count
    wire [7:0]  avg;            // Average from sharer
    wire [35:0] trim;           // Trims from sharer
    wire        boundary;       // End of PWM period
    wire        save;           // Power-save in effect
    wire        wb_req;         // Bus request
    wire [3:0]  en_mask;        // Working phase mask
    integer     k;              // Loop index

    // Count phases from straps
    function [2:0] strap_count;
        input [3:0] gnd;
        begin
            if (gnd[2])
                strap_count = 3'h2;
            else if (gnd[3])
                strap_count = 3'h3;
            else
                strap_count = 3'h4;
        end
    endfunction

    // Low-order phases mask
    function [3:0] count_mask;
        input [2:0] n;
        begin
            count_mask = (4'h1 << n) - 4'h1;
        end
    endfunction

    assign wb_req   = wb_cyc_i & wb_stb_i;
    assign boundary = (pwm_cnt == pwm_per - 8'h01);
    assign en_mask  = count_mask(act_n);
    // Save only while regulating; start-up uses all phases
    assign save     = ~flag_n & (state == ST_RUN);

    // Open-drain pin: low when flag asserted or drivers off
    assign power_save_pin_o    = 1'b0;
    assign power_save_pin_oe_o = ~(flag_n & driver_enable_out_o);

    // Wishbone slave, one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl     <= `LLPM_CTRL_RESET;
            pwm_per  <= `LLPM_PER_RESET;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o) begin
                if (wb_we_i) begin
                    if (wb_adr_i == `LLPM_REG_CTRL) begin
                        if (wb_sel_i[0])
                            ctrl[7:0] <= wb_dat_i[7:0];
                    end else if (wb_adr_i == `LLPM_REG_PWMPER) begin
                        if (wb_sel_i[0] && wb_dat_i[7:0] > 8'h03)
                            pwm_per <= wb_dat_i[7:0];
                    end
                    wb_dat_o <= 32'h0;
                end else if (wb_adr_i == `LLPM_REG_CTRL) begin
                    wb_dat_o <= ctrl;
                end else if (wb_adr_i == `LLPM_REG_STATUS) begin
                    wb_dat_o <= {16'h0, en_mask, 1'b0, act_n, strategy,
                                 fixed_mode_o, flag_n, 1'b0, state};
                end else if (wb_adr_i == `LLPM_REG_PWMPER) begin
                    wb_dat_o <= {24'h0, pwm_per};
                end else if (wb_adr_i == `LLPM_REG_ISHARE) begin
                    wb_dat_o <= {24'h0, average_phase_current_o};
                end else begin
                    wb_dat_o <= 32'h0;
                end
            end
        end
    end

    // Capture flag and codes from voltage-set commands
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_n     <= 1'b1;
            core_vid_o <= 7'h00;
            nb_vid_o   <= 7'h00;
        end else if (fixed_mode_o) begin
            // Lines read as a static code, followed live
            core_vid_o <= {5'h00, fixed_code_o};
            nb_vid_o   <= {5'h00, fixed_code_o};
        end else if (vid_cmd_i) begin
            // Flag is bit seven, active low
            flag_n <= vid_data_i[`LLPM_FLAG_BIT];
            if (vid_core_i)
                core_vid_o <= vid_data_i[6:0];
            // Northbridge code only; flag never touches it
            if (vid_nb_i)
                nb_vid_o <= vid_data_i[6:0];
        end
    end

    // Fixed-voltage mode tracking
    always @(posedge clk_i) begin
        if (rst_i) begin
            fixed_mode_o  <= 1'b0;
            serial_mode_o <= 1'b0;
            fixed_code_o  <= 2'h0;
        end else begin
            fixed_mode_o  <= ~overvoltage_fixmode_pin_n_i;
            serial_mode_o <= ~overvoltage_fixmode_pin_n_i | cpu_power_ok_i;
            fixed_code_o  <= {serial_vid_clock_i, serial_vid_data_i};
        end
    end

    // Sequencer next state
    always @* begin
        next_state = state;
        case (state)
            ST_OFF:  if (ctrl[`LLPM_CTRL_DRVEN]) next_state = ST_SOFT;
            ST_SOFT: if (ctrl[`LLPM_CTRL_SSDONE]) next_state = ST_RUN;
            ST_RUN:  if (!ctrl[`LLPM_CTRL_DRVEN]) next_state = ST_OFF;
            default: next_state = ST_OFF;
        endcase
    end

    // Sequencer, strap and strategy latch
    always @(posedge clk_i) begin
        if (rst_i) begin
            state            <= ST_OFF;
            strategy         <= `LLPM_STRAT_NONE;
            cfg_phases       <= 3'h4;
            power_good_out_o <= 1'b0;
        end else begin
            state            <= next_state;
            power_good_out_o <= (next_state == ST_RUN);
            if (state == ST_OFF)
                cfg_phases <= strap_count(pwm_strap_gnd_i);
            // Strategy stored as power-good rises
            if (state == ST_SOFT && next_state == ST_RUN)
                strategy <= strat_sense_i;
        end
    end

    llpm_phase_sel u_sel (
        .cfg_phases_i  (cfg_phases),
        .strategy_i    (strategy),
        .save_i        (save),
        .drv_hiz_pwm_i (drv_hiz_pwm_i),
        .act_phases_o  (sel_n)
    );

    // Working count at period boundary, frozen in transitions
    always @(posedge clk_i) begin
        if (rst_i) begin
            act_n   <= 3'h4;
            pwm_cnt <= 8'h00;
            duty    <= 8'h00;
        end else begin
            pwm_cnt <= boundary ? 8'h00 : pwm_cnt + 8'h01;
            if (state != ST_RUN)
                act_n <= cfg_phases;
            else if (boundary && !vid_transition_i)
                act_n <= sel_n;
            if (boundary)
                duty <= pwm_per >> 1;
        end
    end

    // Evenly spaced phase PWM; dropped phases floated
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_pwm_out_o     <= 4'h0;
            phase_pwm_oe_o      <= 4'h0;
            driver_enable_out_o <= 1'b0;
            nb_pwm_oe_o         <= 1'b0;
            nb_driver_enable_o  <= 1'b0;
        end else begin
            // Enable held through reduction; section HiZ drops it
            driver_enable_out_o <= (state != ST_OFF) & ~ctrl[`LLPM_CTRL_HIZ];
            phase_pwm_oe_o      <= (state != ST_OFF && !ctrl[`LLPM_CTRL_HIZ]) ?
                                   en_mask : 4'h0;
            // Northbridge follows enable only
            nb_driver_enable_o  <= (state != ST_OFF);
            nb_pwm_oe_o         <= (state != ST_OFF);
            for (k = 0; k < 4; k = k + 1) begin
                phase_pwm_out_o[k] <= en_mask[k] &&
                    ((({2'h0, pwm_cnt} + {2'h0, pwm_per / {5'h0, act_n}} * k[9:0])
                      % {2'h0, pwm_per}) < {2'h0, duty});
            end
        end
    end

    // Sharing divides by working phases
    llpm_share u_share (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cur_i  (phase_current_info_i),
        .en_i   (en_mask),
        .n_i    (act_n),
        .avg_o  (avg),
        .trim_o (trim)
    );

    // Register sharing results
    always @(posedge clk_i) begin
        if (rst_i) begin
            average_phase_current_o <= 8'h00;
            share_trim_o            <= 36'h0;
        end else begin
            average_phase_current_o <= avg;
            share_trim_o            <= trim;
        end
    end

endmodule // llpm_top

// ### common/llpm_map.vh
// Purpose: Constants for the light-load phase manager
// Assumes: 20 MHz core clock, 8-bit current samples
// Notes:   Included by bare name; definitions only
`ifndef LLPM_MAP_VH
`define LLPM_MAP_VH

// Wishbone register byte offsets
`define LLPM_REG_CTRL      4'h0
`define LLPM_REG_STATUS    4'h4
`define LLPM_REG_PWMPER    4'h8
`define LLPM_REG_ISHARE    4'hc

// Control register fields
`define LLPM_CTRL_DRVEN    0
`define LLPM_CTRL_HIZ      1
`define LLPM_CTRL_SSDONE   2
`define LLPM_CTRL_RESET    32'h0000_0000

// Data byte of a voltage-set command
`define LLPM_FLAG_BIT      7

// Strategy codes from the strap sense
`define LLPM_STRAT_NONE    2'h0
`define LLPM_STRAT_CUT1    2'h1
`define LLPM_STRAT_CUT2    2'h2

// PWM period in clocks (20 MHz / 150 kHz, rounded down)
`define LLPM_OSC_KHZ       150
`define LLPM_CLK_KHZ       20000
`define LLPM_PER_RESET     8'h85

`endif

// ### verilog/llpm_phase_sel.v
// Purpose: Enabled-phase set from strap count, strategy and flag
// Assumes: Count 2..4, strategy from strap latch
// Notes:   Pure combinational
`timescale 1ns/10ps
`include "llpm_map.vh"

module llpm_phase_sel (
    input  wire [2:0] cfg_phases_i,   // Strapped phase count
    input  wire [1:0] strategy_i,     // Latched strategy
    input  wire       save_i,         // Power-save active
    input  wire       drv_hiz_pwm_i,  // Drivers tri-state via PWM only
    output reg  [2:0] act_phases_o    // Working phase count
);

    // Drop highest phases; floor of one
    always @* begin
        act_phases_o = cfg_phases_i;
        if (save_i) begin
            if (strategy_i == `LLPM_STRAT_CUT1) begin
                act_phases_o = cfg_phases_i - 3'h1;
            end else if (strategy_i == `LLPM_STRAT_CUT2) begin
                act_phases_o = (cfg_phases_i > 3'h2) ? cfg_phases_i - 3'h2 : 3'h1;
            end
            // Single phase only from three when PWM tri-states the driver
            if (drv_hiz_pwm_i && act_phases_o == 3'h1 && cfg_phases_i != 3'h3) begin
                act_phases_o = 3'h2;
            end
        end
    end

endmodule // llpm_phase_sel

// ### verilog/llpm_share.v
// Purpose: Average-current reference and per-phase trim
// Assumes: Four 8-bit current samples
// Notes:   Divide by working phase count
`timescale 1ns/10ps

module llpm_share (
    input  wire        clk_i,       // Core clock
    input  wire        rst_i,       // Synchronous reset
    input  wire [31:0] cur_i,       // Four 8-bit current samples
    input  wire [3:0]  en_i,        // Working phase mask
    input  wire [2:0]  n_i,         // Working phase count
    output reg  [7:0]  avg_o,       // Average current reference
    output reg  [35:0] trim_o       // Four 9-bit signed errors
);

    reg [9:0] sum;                  // Sum over working phases
    reg [9:0] avg;                  // Quotient
    integer   k;                    // Loop index

    // Sum working phases and divide
    always @* begin
        sum = 10'h000;
        for (k = 0; k < 4; k = k + 1) begin
            if (en_i[k]) begin
                sum = sum + {2'h0, cur_i[k*8 +: 8]};
            end
        end
        case (n_i)
            3'h2:    avg = sum >> 1;
            3'h3:    avg = sum / 10'h003;
            3'h4:    avg = sum >> 2;
            default: avg = sum;
        endcase
    end

    // Register average and per-phase errors
    always @(posedge clk_i) begin
        if (rst_i) begin
            avg_o  <= 8'h00;
            trim_o <= 36'h0;
        end else begin
            avg_o <= avg[7:0];
            for (k = 0; k < 4; k = k + 1) begin
                trim_o[k*9 +: 9] <= en_i[k] ?
                    ({1'b0, avg[7:0]} - {1'b0, cur_i[k*8 +: 8]}) : 9'h000;
            end
        end
    end

endmodule // llpm_share

// ### testbench/llpm_checker_assertions.sv
// Purpose: Port-level assertions for the light-load phase manager
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every llpm_top instance
`timescale 1ns/10ps
module llpm_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire       vid_cmd_i,
    input wire       vid_core_i,
    input wire       vid_nb_i,
    input wire [7:0] vid_data_i,
    input wire       serial_vid_clock_i,
    input wire       serial_vid_data_i,
    input wire       overvoltage_fixmode_pin_n_i,
    input wire       vid_transition_i,
    input wire [3:0] pwm_strap_gnd_i,
    input wire       power_save_pin_o,
    input wire       power_save_pin_oe_o,
    input wire [3:0] phase_pwm_oe_o,
    input wire       driver_enable_out_o,
    input wire       nb_pwm_oe_o,
    input wire       nb_driver_enable_o,
    input wire       power_good_out_o,
    input wire       fixed_mode_o,
    input wire       serial_mode_o,
    input wire [1:0] fixed_code_o,
    input wire [6:0] core_vid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Phases configured by the ground straps
    wire [3:0] cfg_mask = pwm_strap_gnd_i[2] ? 4'h3 : (pwm_strap_gnd_i[3] ? 4'h7 : 4'hf);
    // Bus request waiting for its answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Fixed mode held with static code lines
    sequence s_fix_steady;
        (!overvoltage_fixmode_pin_n_i && $stable({serial_vid_clock_i, serial_vid_data_i}))[*3];
    endsequence
    // Accepted command for the core section
    sequence s_core_cmd;
        vid_cmd_i && vid_core_i && !fixed_mode_o;
    endsequence
    a_bus_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a one cycle answer");
    a_pin_and_drv: assert property (!driver_enable_out_o |-> power_save_pin_oe_o)
        else $error("flag pin released while driver enable low");
    a_pin_open_drain: assert property (power_save_pin_o == 1'b0)
        else $error("flag pin driven high");
    a_drop_highest: assert property ((phase_pwm_oe_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        && ((phase_pwm_oe_o & ~cfg_mask) == 4'h0))
        else $error("phase set not contiguous from phase one");
    a_start_all: assert property ($rose(power_good_out_o) |-> phase_pwm_oe_o == cfg_mask)
        else $error("start-up without all configured phases");
    a_keep_drv_en: assert property (power_good_out_o && $changed(phase_pwm_oe_o)
        && phase_pwm_oe_o != 4'h0 |-> driver_enable_out_o)
        else $error("driver enable dropped on phase change");
    a_fix_enter: assert property (!overvoltage_fixmode_pin_n_i [*3] |-> fixed_mode_o && serial_mode_o)
        else $error("fixed mode not entered");
    a_fix_code: assert property (s_fix_steady ##0 fixed_mode_o
        |-> fixed_code_o == {serial_vid_clock_i, serial_vid_data_i})
        else $error("static code not followed");
    a_hold_trans: assert property (vid_transition_i && $past(vid_transition_i)
        && power_good_out_o |=> $stable(phase_pwm_oe_o))
        else $error("phase set moved during transition");
    a_nb_ignore: assert property (s_core_cmd ##0 !vid_nb_i
        |=> $stable({nb_pwm_oe_o, nb_driver_enable_o}))
        else $error("northbridge section moved on core command");
    a_core_code: assert property (s_core_cmd |=> core_vid_o == $past(vid_data_i[6:0]))
        else $error("core code not taken from data byte");
endmodule // llpm_checker
bind llpm_top llpm_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .vid_cmd_i,
    .vid_core_i, .vid_nb_i, .vid_data_i, .serial_vid_clock_i, .serial_vid_data_i,
    .overvoltage_fixmode_pin_n_i, .vid_transition_i, .pwm_strap_gnd_i, .power_save_pin_o,
    .power_save_pin_oe_o, .phase_pwm_oe_o, .driver_enable_out_o, .nb_pwm_oe_o,
    .nb_driver_enable_o, .power_good_out_o, .fixed_mode_o, .serial_mode_o, .fixed_code_o,
    .core_vid_o);

// ### testbench/llpm_cpu_model.sv
// Purpose: CPU side of the serial VID link and the flag pin wire
// Assumes: Commands arrive already decoded, one byte each
// Notes:   Data lines toggle between commands, never hold
`timescale 1ns/10ps
module llpm_cpu_model (
    input  wire       clk_i,      // Core clock
    input  wire       send_i,     // Issue one voltage-set command
    input  wire       save_n_i,   // Flag, low asks for power save
    input  wire [6:0] code_i,     // VID code
    input  wire [1:0] addr_i,     // Core, northbridge
    input  wire       pin_oe_i,   // Regulator pulls flag pin low
    output reg        cmd_o,      // Command pulse
    output reg  [7:0] data_o,     // Data byte
    output reg        core_o,     // Core addressed
    output reg        nb_o,       // Northbridge addressed
    output wire       pin_o       // Flag pin level
);
    // Pull-up on the open-drain pin
    assign pin_o = pin_oe_i ? 1'b0 : 1'b1;
    initial begin
        cmd_o = 1'b0;
        data_o = 8'h00;
        core_o = 1'b0;
        nb_o = 1'b0;
    end
    // One cycle pulse per command, flag in top bit
    always @(posedge clk_i) begin
        cmd_o <= send_i;
        data_o <= send_i ? {save_n_i, code_i} : ~data_o;
        {core_o, nb_o} <= send_i ? addr_i : ~{core_o, nb_o};
    end
endmodule // llpm_cpu_model

// ### testbench/llpm_top_test.sv
// Purpose: Self-checking bench of the light-load phase manager
// Assumes: Period register left at its reset value
// Notes:   Waits of 300 cycles cover two PWM periods
`timescale 1ns/10ps
module llpm_top_test;
    reg         clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg  [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf, pwm_strap_gnd_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0, phase_current_info_i = 32'h0, rd, seed = 32'd9795;
    reg         serial_vid_clock_i = 0, serial_vid_data_i = 0, cpu_power_ok_i = 0;
    reg         overvoltage_fixmode_pin_n_i = 1, vid_transition_i = 0, drv_hiz_pwm_i = 0;
    reg         send = 0, save_n = 1;
    reg  [1:0]  strat_sense_i = 2'h0, addr = 2'h2;
    reg  [6:0]  code = 7'h0;
    wire [31:0] wb_dat_o;
    wire [35:0] share_trim_o;
    wire [7:0]  vid_data_i, average_phase_current_o;
    wire [6:0]  core_vid_o, nb_vid_o;
    wire [3:0]  phase_pwm_out_o, phase_pwm_oe_o;
    wire [1:0]  fixed_code_o;
    wire        wb_ack_o, vid_cmd_i, vid_core_i, vid_nb_i, power_save_pin_i, power_save_pin_o;
    wire        power_save_pin_oe_o, driver_enable_out_o, nb_pwm_oe_o, nb_driver_enable_o;
    wire        power_good_out_o, fixed_mode_o, serial_mode_o;
    integer     bad_count = 0, samples_checked = 0, i;
    llpm_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .vid_cmd_i, .vid_core_i, .vid_nb_i, .vid_data_i,
        .serial_vid_clock_i, .serial_vid_data_i, .cpu_power_ok_i, .overvoltage_fixmode_pin_n_i,
        .vid_transition_i, .drv_hiz_pwm_i, .strat_sense_i, .power_save_pin_i,
        .power_save_pin_o, .power_save_pin_oe_o, .pwm_strap_gnd_i, .phase_current_info_i,
        .phase_pwm_out_o, .phase_pwm_oe_o, .driver_enable_out_o, .nb_pwm_oe_o,
        .nb_driver_enable_o, .power_good_out_o, .fixed_mode_o, .serial_mode_o, .fixed_code_o,
        .core_vid_o, .nb_vid_o, .average_phase_current_o, .share_trim_o);
    llpm_cpu_model u_cpu (.clk_i(clk_i), .send_i(send), .save_n_i(save_n), .code_i(code),
        .addr_i(addr), .pin_oe_i(power_save_pin_oe_o), .cmd_o(vid_cmd_i), .data_o(vid_data_i),
        .core_o(vid_core_i), .nb_o(vid_nb_i), .pin_o(power_save_pin_i));
    // 20 MHz clock
    initial forever #25 clk_i = ~clk_i;
    // Xorshift step
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    // Working phase count from straps, strategy and flag
    function integer exp_n(input [3:0] st, input [1:0] sg, input sv, input hz);
        integer n;
        begin
            n = st[2] ? 2 : (st[3] ? 3 : 4);
            exp_n = n;
            if (sv && sg != 2'h0 && sg != 2'h3) exp_n = n - sg;
            if (exp_n < 1) exp_n = 1;
            if (hz && exp_n == 1 && n != 3) exp_n = 2;
        end
    endfunction
    // Average over the first c samples
    function [7:0] exp_avg(input integer c);
        integer k, s;
        begin
            s = 0;
            for (k = 0; k < c; k = k + 1) s = s + phase_current_info_i[8*k +: 8];
            exp_avg = s / c;
        end
    endfunction
    task check(input [35:0] seen, input [35:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // One classic Wishbone cycle, read data into rd
    task wb(input we, input [3:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge clk_i);
            {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
            t = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && t < 20) begin
                @(posedge clk_i);
                t = t + 1;
            end
            if (wb_ack_o !== 1'b1) begin
                bad_count = bad_count + 1;
                stop_test;
            end
            rd = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask
    // Voltage-set command with random code
    task cpu_send(input f);
        begin
            seed = xs(seed);
            @(posedge clk_i);
            {send, save_n, code, addr} <= {1'b1, f, seed[6:0], 1'b1, seed[7]};
            @(posedge clk_i);
            send <= 1'b0;
            repeat (3) @(posedge clk_i);
            check(core_vid_o, code);
            check(power_save_pin_oe_o, !f);
        end
    endtask
    // Bring up one configuration and walk flag assert, transition, release
    task run_cfg(input [3:0] st, input [1:0] sg, input hz);
        integer c;
        reg [1:0] nb;
        begin
            seed = xs(seed);
            {rst_i, pwm_strap_gnd_i, strat_sense_i, drv_hiz_pwm_i} <= {1'b1, st, sg, hz};
            phase_current_info_i <= seed;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            if (seed[1]) cpu_send(1'b0);
            wb(1, 4'h0, 32'h1);
            wb(1, 4'h0, 32'h5);
            c = exp_n(st, sg, 0, hz);
            check(phase_pwm_oe_o, (4'h1 << c) - 1);
            nb = {nb_pwm_oe_o, nb_driver_enable_o};
            strat_sense_i <= ~sg;
            cpu_send(1'b0);
            repeat (300) @(posedge clk_i);
            c = exp_n(st, sg, 1, hz);
            check(phase_pwm_oe_o, (4'h1 << c) - 1);
            check({driver_enable_out_o, nb_pwm_oe_o, nb_driver_enable_o}, {1'b1, nb});
            check(average_phase_current_o, exp_avg(c));
            check(share_trim_o[8:0], ({1'b0, exp_avg(c)} - phase_current_info_i[7:0]) & 9'h1ff);
            check(phase_pwm_out_o & ~((4'h1 << c) - 1), 4'h0);
            wb(0, 4'hc, 32'h0);
            check(rd, {24'h0, exp_avg(c)});
            vid_transition_i <= 1'b1;
            cpu_send(1'b1);
            repeat (300) @(posedge clk_i);
            check(phase_pwm_oe_o, (4'h1 << c) - 1);
            vid_transition_i <= 1'b0;
            repeat (300) @(posedge clk_i);
            c = exp_n(st, sg, 0, hz);
            check(phase_pwm_oe_o, (4'h1 << c) - 1);
            check(average_phase_current_o, exp_avg(c));
        end
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count = bad_count + 1;
        stop_test;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        check(power_save_pin_oe_o, 1'b1);
        wb(0, 4'h4, 32'h0);
        check(rd[2:0], 3'h1);
        wb(1, 4'h8, 32'h3);
        wb(0, 4'h8, 32'h0);
        check(rd, 32'h85);
        wb(0, 4'h1, 32'h0);
        check(rd, 32'h0);
        for (i = 0; i < 9; i = i + 1) begin
            seed = xs(seed);
            run_cfg((i % 3 == 0) ? 4'h4 : ((i % 3 == 1) ? 4'h8 : 4'h0), i / 3, seed[0]);
        end
        wb(1, 4'h0, 32'h7);
        repeat (2) @(posedge clk_i);
        check({phase_pwm_oe_o, driver_enable_out_o, power_save_pin_oe_o}, 6'h01);
        overvoltage_fixmode_pin_n_i <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            @(posedge clk_i);
            {serial_vid_clock_i, serial_vid_data_i, cpu_power_ok_i} <= seed[2:0];
            repeat (4) @(posedge clk_i);
            check({fixed_mode_o, serial_mode_o, fixed_code_o}, {2'h3, seed[2:1]});
            check({core_vid_o, nb_vid_o}, {5'h0, seed[2:1], 5'h0, seed[2:1]});
        end
        stop_test;
    end
endmodule // llpm_top_test
